// *** dv/mio_host_model.sv ***
`timescale 1ns/100ps
module mio_host_model import mio_pkg::*; (
	input wire logic clk_sys,
	input wire mio_din_s din_want,
	output mio_din_s din
);
	// ************************************
	// Discrete lines of the host
	// ************************************
	// Lines move just after the edge, like a real clocked host, never mid-cycle
	initial din = '0;
	always @(posedge clk_sys) begin
		din <= din_want;
	end
endmodule

// *** dv/test_motion_io_config_routing.sv ***
`timescale 1ns/100ps
module test_motion_io_config_routing import mio_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [5:0] wb_adr = '0;
	logic [3:0] wb_sel = '0;
	logic [31:0] wb_dat = '0, wb_dat_o, q;
	logic wb_ack_o;
	mio_din_s din_want = '0, din;
	mio_fn_s fn_in = '0;
	logic [POS_W-1:0] motor_pos = '0;
	logic homing_active = 1'b0, enc_present = 1'b0;
	mio_cmd_s cmd;
	logic go1, go2, go3, go4, win, enp;
	logic [6:0] run_pct, stand_pct;
	logic [POS_W-1:0] pre_pos, enc_pre;
	int error_cnt = 0, comparisons = 0, cycles = 0;

	always #2 clk_sys = ~clk_sys;

	mio_host_model host (.clk_sys(clk_sys), .din_want(din_want), .din(din));
	mio_routing_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din(din), .fn_in(fn_in),
		.motor_pos(motor_pos), .homing_active(homing_active), .enc_present(enc_present),
		.cmd(cmd), .general_output_1(go1), .general_output_2(go2), .general_output_3(go3),
		.general_output_4(go4), .position_window_flag(win), .run_current_pct(run_pct),
		.standstill_pct(stand_pct), .preset_pos(pre_pos), .enc_preset(enc_pre),
		.enc_preset_en(enp));

	// ************************************
	// Shared tasks
	// ************************************
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs well under two thousand cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until ack is seen; data taken in the ack cycle, released after
	task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat <= d;
		// Ends on ack; with no ack only the bench timeout ends this wait
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic settle;
		// Reads after an edge see values held since the edge before
		repeat (4) @(posedge clk_sys);
	endtask

	// ************************************
	// Scenarios
	// ************************************
	task automatic t_reset;
		wb(0, ADR_SRC, 0); check("src", q, 32'h0000005f);
		wb(0, ADR_POL, 0); check("pol", q, 32'h00000101);
		wb(0, ADR_OSEL, 0); check("osel", q, 32'h09080705);
		wb(0, ADR_CUR, 0); check("cur", q, 32'h00003264);
		check("pcts", {run_pct, stand_pct}, {7'h64, 7'h32});
		wb(0, 6'h28, 0); check("unmapped", q, 32'h00000000);
		wb(1, ADR_PRE, 32'h00abcdef); wb(1, ADR_ENC, 32'h00123456); settle;
		check("presets", {pre_pos, enc_pre}, {24'habcdef, 24'h123456});
		check("enc_en", enp, 1'b0);
	endtask

	task automatic t_start;
		din_want.start <= 1'b1; settle;
		check("start io", cmd.start, 1'b1);
		wb(1, ADR_SRC, 32'h0000005e); settle;
		check("start ser 0", cmd.start, 1'b0);
		wb(1, ADR_SER, 32'h00000001); settle;
		check("start ser 1", cmd.start, 1'b1);
		din_want.start <= 1'b0;
	endtask

	task automatic t_stop;
		logic [1:0] a;
		for (int i = 0; i < 4; i++) begin
			// Code bit 0 asks for deceleration, bit 1 for current off
			a = {i[0], i[1]};
			wb(1, ADR_POL, 32'h00000001 | (i << 8)); settle;
			check("stop act", {cmd.stop, cmd.stop_decel, cmd.stop_cur_off}, {1'b1, a});
		end
		din_want.stop <= 1'b1; settle;
		check("stop nc closed", cmd.stop, 1'b0);
		wb(1, ADR_POL, 32'h00000100); settle;
		check("stop no closed", cmd.stop, 1'b1);
		wb(1, ADR_SRC, 32'h0000005d); settle;
		check("stop io off", cmd.stop, 1'b0);
		wb(1, ADR_SER, 32'h00000002); settle;
		check("stop ser", cmd.stop, 1'b1);
		din_want.stop <= 1'b0;
		wb(1, ADR_SER, 0);
	endtask

	task automatic t_excite_jog;
		din_want.release_in <= 1'b1; din_want.home <= 1'b1; din_want.forward_jog_request <= 1'b1;
		din_want.reverse_jog_request <= 1'b1; din_want.operation_select_bits <= 6'h2a; settle;
		check("rel no", cmd.release_act, 1'b1);
		check("io jog", {cmd.home_req, cmd.preset_req, cmd.forward_jog_request, cmd.op_sel}, 9'h16a);
		check("io rvs", cmd.reverse_jog_request, 1'b1);
		wb(1, ADR_SRC, 32'h00000063); wb(1, ADR_POL, 32'h00000104); settle;
		check("preset sw", {cmd.home_req, cmd.preset_req}, 2'b00);
		check("rel nc", cmd.release_act, 1'b0);
		check("ser ops", {cmd.forward_jog_request, cmd.op_sel, cmd.excite}, 8'h00);
		wb(1, ADR_SER, 32'h00001518); settle;
		check("ser preset", {cmd.preset_req, cmd.forward_jog_request, cmd.op_sel}, 8'hd5);
		check("exc 0", cmd.excite, 1'b0);
		wb(1, ADR_POL, 32'h00000102); settle;
		check("exc inv", cmd.excite, 1'b1);
		wb(1, ADR_SER, 32'h00000004); settle;
		check("exc inv 1", cmd.excite, 1'b0);
		din_want <= '0;
		wb(1, ADR_SER, 0);
		wb(1, ADR_SRC, 32'h0000005f);
		wb(1, ADR_POL, 32'h00000101);
	endtask

	task automatic t_limits;
		din_want.limit_pos <= 1'b1; din_want.home_sensor <= 1'b1; settle;
		check("ot", {cmd.ot_pos, cmd.ot_neg, cmd.ot_decel, cmd.home_hit}, 4'b1001);
		wb(1, ADR_SRC, 32'h0000009f); wb(1, ADR_POL, 32'h00000139); settle;
		check("ot off", {cmd.ot_pos, cmd.ot_neg, cmd.ot_decel}, 3'b000);
		check("nc", {cmd.home_hit, cmd.sensor_a_hit}, 2'b01);
		homing_active <= 1'b1; settle;
		check("ot homing", {cmd.ot_pos, cmd.ot_neg, cmd.ot_decel}, 3'b011);
		homing_active <= 1'b0; din_want <= '0;
		wb(1, ADR_SRC, 32'h0000005f); wb(1, ADR_POL, 32'h00000101);
	endtask

	task automatic t_window;
		logic [POS_W-1:0] pos [4];
		logic exp [4];
		pos = '{24'hfffff6, 24'hfffff5, 24'h000014, 24'h000015};
		exp = '{1'b1, 1'b0, 1'b1, 1'b0};
		wb(1, ADR_AREA1, 32'h00fffff6); wb(1, ADR_AREA2, 32'h00000014);
		for (int i = 0; i < 4; i++) begin
			motor_pos <= pos[i]; settle;
			check("window", win, exp[i]);
		end
	endtask

	task automatic t_outputs;
		logic [6:0] f;
		logic [3:0] r;
		logic a;
		logic v;
		enc_present <= 1'b1;
		for (int k = 5; k <= 16; k++) begin
			for (int j = 0; j < 2; j++) begin
				v = j[0];
				f = {7{~v}}; r = {4{~v}}; a = ~v;
				case (k)
					5: a = v;
					6, 7, 8, 9, 10: f[12 - k] = v;
					11, 12: r[k - 11] = v;
					13, 14: f[14 - k] = v;
					default: r[k - 13] = v;
				endcase
				motor_pos <= a ? 24'h000000 : 24'h000100;
				fn_in <= f;
				wb(1, ADR_SER, {12'h0, r, 16'h0});
				wb(1, ADR_OSEL, {4{3'h0, k[4:0]}}); settle;
				check("outputs", {go1, go2, go3, go4}, {4{v}});
			end
		end
		check("enc_en on", enp, 1'b1);
		fn_in <= 7'h7f; enc_present <= 1'b0;
		wb(1, ADR_OSEL, 32'h0a0d0a0d); settle;
		check("no encoder", {go1, go2, go3, go4, enp}, 5'h00);
	endtask

	task automatic t_current;
		wb(1, ADR_CUR, 32'h00000203); settle;
		check("cur lo", {run_pct, stand_pct}, {7'h05, 7'h05});
		wb(1, ADR_CUR, 32'h00007f7f); settle;
		check("cur hi", {run_pct, stand_pct}, {7'h64, 7'h32});
		wb(1, ADR_CUR, 32'h00001e4b); wb(0, ADR_CUR, 0);
		check("cur mid", q, 32'h00001e4b);
	endtask

	// Mid-run reset must restore the working copy and the selector defaults
	task automatic t_rerun;
		wb(1, ADR_SRC, 32'h00000000); wb(1, ADR_OSEL, 32'h07070707);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("reset outs", {go1, go2, go3, go4, win}, 5'h00);
		check("reset pcts", {run_pct, stand_pct}, {7'h64, 7'h32});
		rst_b <= 1'b1;
		@(posedge clk_sys);
		wb(0, ADR_SRC, 0); check("src again", q, 32'h0000005f);
		settle;
		check("sel defaults", {go1, go2, go3, go4}, 4'b0111);
		wb(0, ADR_STAT, 0); check("status", q, 32'h000e0006);
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_start();
		t_stop();
		t_excite_jog();
		t_limits();
		t_window();
		t_outputs();
		t_current();
		t_rerun();
		wrap_up();
	end
endmodule

// *** verilog/mio_out_mux.sv ***
`timescale 1ns/100ps
module mio_out_mux import mio_pkg::*; (
	input wire logic [OSEL_W-1:0] sel,
	input wire mio_fn_s fn,
	input wire logic area,
	input wire logic [3:0] remote,
	input wire logic enc_present,
	output logic out_bit
);

	// Encoder-based functions read low when no encoder is fitted
	wire logic enc_zero = fn.encoder_zero_flag & enc_present;
	wire logic enc_miss = fn.misstep & enc_present;

	always_comb begin
		case (sel)
			OS_AREA: out_bit = area;
			OS_TIM: out_bit = fn.step_timing_flag;
			OS_READY: out_bit = fn.ready;
			OS_WARN: out_bit = fn.warning_flag;
			OS_HOMEP: out_bit = fn.home_pos;
			OS_ZERO: out_bit = enc_zero;
			OS_ROUT1: out_bit = remote[0];
			OS_ROUT2: out_bit = remote[1];
			OS_MISS: out_bit = enc_miss;
			OS_HEAT: out_bit = fn.overheat;
			OS_ROUT3: out_bit = remote[2];
			OS_ROUT4: out_bit = remote[3];
			default: out_bit = 1'b0;
		endcase
	end

endmodule

// *** verilog/mio_pkg.sv ***
package mio_pkg;

	// ************************************
	// Register map (byte addresses)
	// ************************************
	localparam logic [5:0] ADR_SRC = 6'h00;
	localparam logic [5:0] ADR_POL = 6'h04;
	localparam logic [5:0] ADR_OSEL = 6'h08;
	localparam logic [5:0] ADR_PRE = 6'h0c;
	localparam logic [5:0] ADR_AREA1 = 6'h10;
	localparam logic [5:0] ADR_AREA2 = 6'h14;
	localparam logic [5:0] ADR_ENC = 6'h18;
	localparam logic [5:0] ADR_CUR = 6'h1c;
	localparam logic [5:0] ADR_SER = 6'h20;
	localparam logic [5:0] ADR_STAT = 6'h24;

	// Source register: in bits 0 and 2 to 4, 1 selects discrete I/O, 0 the serial link
	localparam int B_START_SRC = 0;
	localparam int B_STOP_EN = 1;
	localparam int B_EXC_SRC = 2;
	localparam int B_JOG_SRC = 3;
	localparam int B_DATA_SRC = 4;
	localparam int B_HOME_SW = 5;
	localparam int B_HWOT_EN = 6;
	localparam int B_OT_DECEL = 7;
	localparam logic [31:0] SRC_RST = 32'h0000005f;
	localparam logic [31:0] SRC_MASK = 32'h000000ff;

	// Polarity register: in bits 0 and 2 to 5, 1 means normally closed contact
	localparam int B_STOP_NC = 0;
	localparam int B_CON_INV = 1;
	localparam int B_REL_NC = 2;
	localparam int B_LS_NC = 3;
	localparam int B_HS_NC = 4;
	localparam int B_SENSOR_A_NC = 5;
	localparam int B_ACT_LO = 8;
	localparam int B_ACT_HI = 9;
	localparam logic [31:0] POL_RST = 32'h00000101;
	localparam logic [31:0] POL_MASK = 32'h0000033f;

	// Output selectors: 5-bit code per output, one byte apart
	localparam int OSEL_W = 5;
	localparam int OSEL_STEP = 8;
	localparam logic [31:0] OSEL_RST = 32'h09080705;
	localparam logic [31:0] OSEL_MASK = 32'h1f1f1f1f;

	localparam int POS_W = 24;
	localparam logic [31:0] POS_MASK = 32'h00ffffff;
	localparam logic [31:0] POS_RST = 32'h00000000;

	// Current register: run percent [6:0], standstill percent [14:8]
	localparam int CUR_STAND_LSB = 8;
	localparam logic [31:0] CUR_RST = 32'h00003264;
	localparam logic [31:0] CUR_MASK = 32'h00007f7f;
	localparam logic [6:0] CUR_MIN = 7'h05;
	localparam logic [6:0] RUN_MAX = 7'h64;
	localparam logic [6:0] STAND_MAX = 7'h32;

	// Serial command image
	localparam int B_SER_START = 0;
	localparam int B_SER_STOP = 1;
	localparam int B_SER_CON = 2;
	localparam int B_SER_HOME = 3;
	localparam int B_SER_FWD = 4;
	localparam int B_SER_RVS = 5;
	localparam int SER_OPS_LSB = 8;
	localparam int SER_ROUT_LSB = 16;
	localparam logic [31:0] SER_RST = 32'h00000000;
	localparam logic [31:0] SER_MASK = 32'h000f3f3f;

	typedef enum logic [4:0] {
		OS_AREA = 5'h05,
		OS_TIM = 5'h06,
		OS_READY = 5'h07,
		OS_WARN = 5'h08,
		OS_HOMEP = 5'h09,
		OS_ZERO = 5'h0a,
		OS_ROUT1 = 5'h0b,
		OS_ROUT2 = 5'h0c,
		OS_MISS = 5'h0d,
		OS_HEAT = 5'h0e,
		OS_ROUT3 = 5'h0f,
		OS_ROUT4 = 5'h10
	} mio_osel_e;

	typedef struct packed {
		logic start;
		logic stop;
		logic excite;
		logic release_in;
		logic home;
		logic forward_jog_request;
		logic reverse_jog_request;
		logic [5:0] operation_select_bits;
		logic limit_pos;
		logic limit_neg;
		logic home_sensor;
		logic sensor_a;
	} mio_din_s;

	typedef struct packed {
		logic step_timing_flag;
		logic ready;
		logic warning_flag;
		logic home_pos;
		logic encoder_zero_flag;
		logic misstep;
		logic overheat;
	} mio_fn_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic stop_decel;
		logic stop_cur_off;
		logic excite;
		logic release_act;
		logic home_req;
		logic preset_req;
		logic forward_jog_request;
		logic reverse_jog_request;
		logic [5:0] op_sel;
		logic ot_pos;
		logic ot_neg;
		logic ot_decel;
		logic home_hit;
		logic sensor_a_hit;
	} mio_cmd_s;

	// ************************************
	// Shared helpers
	// ************************************
	function automatic logic contact_active(input logic raw, input logic nc);
		contact_active = raw ^ nc;
	endfunction

	function automatic logic [6:0] pct_clamp(input logic [6:0] v, input logic [6:0] hi);
		pct_clamp = (v < CUR_MIN) ? CUR_MIN : ((v > hi) ? hi : v);
	endfunction

endpackage

// *** verilog/mio_routing_top.sv ***
// Notes on behaviour
// - Start from serial at 0, discrete at 1
// - Discrete stop ignored when stop-enable is 0
// - Stop action code chooses decel and current-off
// - Stop input polarity: 0 open, 1 closed
// - Serial excitation bit inverted when logic is 1
// - Serial excitation at power-on follows logic setting
// - Each output shows function its selector picks
// - Selectors reset to codes 5,7,8,9
// - Shared input: home seek or position preset
// - Home, forward, reverse source selectable
// - Excitation and data-select sources selectable
// - Winding-release input polarity selectable
// - Limits honoured while homing even if disabled
// - Limit, home, sensor_a polarity selectable
// - Overtravel: immediate or decelerating stop
// - Window flag while position between two bounds
// - Hold preset position and encoder preset
// - Misstep and encoder zero need encoder
// - Running current 5 to 100 percent
// - Standstill ratio 5 to 50 percent
// - Bus writes touch only working copy
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module mio_routing_top import mio_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire mio_din_s din,
	input wire mio_fn_s fn_in,
	input wire logic [POS_W-1:0] motor_pos,
	input wire logic homing_active,
	input wire logic enc_present,
	output mio_cmd_s cmd,
	output logic general_output_1,
	output logic general_output_2,
	output logic general_output_3,
	output logic general_output_4,
	output logic position_window_flag,
	output logic [6:0] run_current_pct,
	output logic [6:0] standstill_pct,
	output logic [POS_W-1:0] preset_pos,
	output logic [POS_W-1:0] enc_preset,
	output logic enc_preset_en
);

	// ************************************
	// Local helpers
	// ************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
		merge = (old & ~lanes) | (dat & lanes);
	endfunction

	function automatic logic in_window(input logic [POS_W-1:0] p, input logic [POS_W-1:0] a,
		input logic [POS_W-1:0] b);
		logic signed [POS_W-1:0] sp;
		logic signed [POS_W-1:0] sa;
		logic signed [POS_W-1:0] sb;
		sp = p;
		sa = a;
		sb = b;
		in_window = (sa <= sb) ? (sp >= sa && sp <= sb) : (sp >= sb && sp <= sa);
	endfunction

	// ************************************
	// Register bank
	// ************************************
	logic [31:0] src_r;
	logic [31:0] pol_r;
	logic [31:0] osel_r;
	logic [31:0] pre_r;
	logic [31:0] area1_r;
	logic [31:0] area2_r;
	logic [31:0] enc_r;
	logic [31:0] cur_r;
	logic [31:0] ser_r;
	logic [31:0] stat_w;

	wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wr_en = bus_req & wb_we_i;
	wire logic [31:0] cur_merged = merge(cur_r, wb_dat_i, wb_sel_i, CUR_MASK);
	wire logic [6:0] run_fix = pct_clamp(cur_merged[6:0], RUN_MAX);
	wire logic [6:0] stand_fix = pct_clamp(cur_merged[CUR_STAND_LSB +: 7], STAND_MAX);

	// Reset reloads the retained image; bus writes alter only this working copy
	// working copy
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			src_r <= SRC_RST;
			pol_r <= POL_RST;
			osel_r <= OSEL_RST;
			pre_r <= POS_RST;
			area1_r <= POS_RST;
			area2_r <= POS_RST;
			enc_r <= POS_RST;
			cur_r <= CUR_RST;
			ser_r <= SER_RST;
		end else if (wr_en) begin
			case (wb_adr_i)
				ADR_SRC: src_r <= merge(src_r, wb_dat_i, wb_sel_i, SRC_MASK);
				ADR_POL: pol_r <= merge(pol_r, wb_dat_i, wb_sel_i, POL_MASK);
				ADR_OSEL: osel_r <= merge(osel_r, wb_dat_i, wb_sel_i, OSEL_MASK);
				ADR_PRE: pre_r <= merge(pre_r, wb_dat_i, wb_sel_i, POS_MASK);
				ADR_AREA1: area1_r <= merge(area1_r, wb_dat_i, wb_sel_i, POS_MASK);
				ADR_AREA2: area2_r <= merge(area2_r, wb_dat_i, wb_sel_i, POS_MASK);
				ADR_ENC: enc_r <= merge(enc_r, wb_dat_i, wb_sel_i, POS_MASK);
				ADR_CUR: cur_r <= {17'h00000, stand_fix, 1'b0, run_fix};
				ADR_SER: ser_r <= merge(ser_r, wb_dat_i, wb_sel_i, SER_MASK);
				default: ;
			endcase
		end
	end

	// Unmapped addresses still ack and read as zero so a stray access cannot hang
	wire logic [31:0] rd_data =
		(wb_adr_i == ADR_SRC) ? src_r :
		(wb_adr_i == ADR_POL) ? pol_r :
		(wb_adr_i == ADR_OSEL) ? osel_r :
		(wb_adr_i == ADR_PRE) ? pre_r :
		(wb_adr_i == ADR_AREA1) ? area1_r :
		(wb_adr_i == ADR_AREA2) ? area2_r :
		(wb_adr_i == ADR_ENC) ? enc_r :
		(wb_adr_i == ADR_CUR) ? cur_r :
		(wb_adr_i == ADR_SER) ? ser_r :
		(wb_adr_i == ADR_STAT) ? stat_w : 32'h00000000;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

	// ************************************
	// Input routing and polarity
	// ************************************
	mio_cmd_s cmd_nxt;
	wire logic stop_seen = contact_active(din.stop, pol_r[B_STOP_NC]);
	wire logic ls_pos = contact_active(din.limit_pos, pol_r[B_LS_NC]);
	wire logic ls_neg = contact_active(din.limit_neg, pol_r[B_LS_NC]);
	wire logic ot_enable = src_r[B_HWOT_EN] | homing_active;
	wire logic jog_io = src_r[B_JOG_SRC];
	wire logic home_in = jog_io ? din.home : ser_r[B_SER_HOME];
	wire logic ser_excite = ser_r[B_SER_CON] ^ pol_r[B_CON_INV];

	assign cmd_nxt.start = src_r[B_START_SRC] ? din.start : ser_r[B_SER_START];
	assign cmd_nxt.stop = (src_r[B_STOP_EN] & stop_seen) | ser_r[B_SER_STOP];
	assign cmd_nxt.stop_decel = cmd_nxt.stop & pol_r[B_ACT_LO];
	assign cmd_nxt.stop_cur_off = cmd_nxt.stop & pol_r[B_ACT_HI];
	// excitation; cleared serial bit means logic bit at reset
	assign cmd_nxt.excite = src_r[B_EXC_SRC] ? din.excite : ser_excite;
	assign cmd_nxt.release_act = contact_active(din.release_in, pol_r[B_REL_NC]);
	assign cmd_nxt.home_req = home_in & ~src_r[B_HOME_SW];
	assign cmd_nxt.preset_req = home_in & src_r[B_HOME_SW];
	assign cmd_nxt.forward_jog_request = jog_io ? din.forward_jog_request : ser_r[B_SER_FWD];
	assign cmd_nxt.reverse_jog_request = jog_io ? din.reverse_jog_request : ser_r[B_SER_RVS];
	assign cmd_nxt.op_sel = src_r[B_DATA_SRC] ? din.operation_select_bits :
		ser_r[SER_OPS_LSB +: 6];
	assign cmd_nxt.ot_pos = ot_enable & ls_pos;
	assign cmd_nxt.ot_neg = ot_enable & ls_neg;
	assign cmd_nxt.ot_decel = (cmd_nxt.ot_pos | cmd_nxt.ot_neg) & src_r[B_OT_DECEL];
	assign cmd_nxt.home_hit = contact_active(din.home_sensor, pol_r[B_HS_NC]);
	assign cmd_nxt.sensor_a_hit = contact_active(din.sensor_a, pol_r[B_SENSOR_A_NC]);

	// ************************************
	// Output functions
	// ************************************
	// position window
	wire logic window_nxt = in_window(motor_pos, area1_r[POS_W-1:0], area2_r[POS_W-1:0]);
	logic [3:0] gen_nxt;

	for (genvar g = 0; g < 4; g++) begin : g_out
		mio_out_mux u_mux (
			.sel(osel_r[g*OSEL_STEP +: OSEL_W]),
			.fn(fn_in),
			.area(window_nxt),
			.remote(ser_r[SER_ROUT_LSB +: 4]),
			.enc_present(enc_present),
			.out_bit(gen_nxt[g])
		);
	end

	// Registering costs a cycle but keeps every output glitch free
	// registered outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cmd <= '0;
			general_output_1 <= 1'b0;
			general_output_2 <= 1'b0;
			general_output_3 <= 1'b0;
			general_output_4 <= 1'b0;
			position_window_flag <= 1'b0;
		end else begin
			cmd <= cmd_nxt;
			general_output_1 <= gen_nxt[0];
			general_output_2 <= gen_nxt[1];
			general_output_3 <= gen_nxt[2];
			general_output_4 <= gen_nxt[3];
			position_window_flag <= window_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			run_current_pct <= CUR_RST[6:0];
			standstill_pct <= CUR_RST[CUR_STAND_LSB +: 7];
			preset_pos <= POS_RST[POS_W-1:0];
			enc_preset <= POS_RST[POS_W-1:0];
			enc_preset_en <= 1'b0;
		end else begin
			run_current_pct <= cur_r[6:0];
			standstill_pct <= cur_r[CUR_STAND_LSB +: 7];
			preset_pos <= pre_r[POS_W-1:0];
			enc_preset <= enc_r[POS_W-1:0];
			enc_preset_en <= enc_present;
		end
	end

	assign stat_w = {11'h000, position_window_flag, general_output_4, general_output_3,
		general_output_2, general_output_1, 1'b0, cmd.sensor_a_hit, cmd.home_hit, cmd.ot_decel,
		cmd.ot_neg, cmd.ot_pos, cmd.reverse_jog_request, cmd.forward_jog_request, cmd.preset_req, cmd.home_req,
		cmd.release_act, cmd.excite, cmd.stop_cur_off, cmd.stop_decel, cmd.stop, cmd.start};

	// ************************************
	// Assertions
	// ************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_inside;
		in_window(motor_pos, area1_r[POS_W-1:0], area2_r[POS_W-1:0]);
	endsequence

	sequence s_homing_limit;
		homing_active && contact_active(din.limit_neg, pol_r[B_LS_NC]);
	endsequence

	property p_start_io;
		src_r[B_START_SRC] |=> cmd.start == $past(din.start);
	endproperty
	a_start_io: assert property (p_start_io) else $error("start not from discrete");

	property p_stop_off;
		!src_r[B_STOP_EN] && !ser_r[B_SER_STOP] |=> !cmd.stop;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("discrete stop not ignored");

	property p_stop_act;
		cmd_nxt.stop |=> cmd.stop_decel == $past(pol_r[B_ACT_LO])
			&& cmd.stop_cur_off == $past(pol_r[B_ACT_HI]);
	endproperty
	a_stop_act: assert property (p_stop_act) else $error("stop action wrong");

	property p_stop_nc;
		src_r[B_STOP_EN] && pol_r[B_STOP_NC] && !din.stop |=> cmd.stop;
	endproperty
	a_stop_nc: assert property (p_stop_nc) else $error("closed contact stop missed");

	property p_excite;
		!src_r[B_EXC_SRC] |=> cmd.excite == ($past(ser_r[B_SER_CON]) ^ $past(pol_r[B_CON_INV]));
	endproperty
	a_excite: assert property (p_excite) else $error("serial excitation wrong");

	property p_ready_out;
		osel_r[OSEL_W-1:0] == OS_READY |=> general_output_1 == $past(fn_in.ready);
	endproperty
	a_ready_out: assert property (p_ready_out) else $error("output 1 not ready");

	property p_preset_sel;
		src_r[B_HOME_SW] |=> !cmd.home_req;
	endproperty
	a_preset_sel: assert property (p_preset_sel) else $error("home request leaked");

	property p_homing_ls;
		s_homing_limit |=> cmd.ot_neg ##1 position_window_flag == $past(window_nxt);
	endproperty
	a_homing_ls: assert property (p_homing_ls) else $error("limit ignored in homing");

	property p_window;
		s_inside |=> position_window_flag;
	endproperty
	a_window: assert property (p_window) else $error("window flag missing");

	property p_cur_range;
		cur_r[6:0] >= CUR_MIN && cur_r[6:0] <= RUN_MAX
			&& cur_r[CUR_STAND_LSB +: 7] <= STAND_MAX;
	endproperty
	a_cur_range: assert property (p_cur_range) else $error("current out of range");

	property p_sel_reset;
		$rose(rst_b) |-> osel_r == OSEL_RST && src_r == SRC_RST;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("selector defaults lost");

	property p_jog_ser;
		!src_r[B_JOG_SRC] |=> cmd.forward_jog_request == $past(ser_r[B_SER_FWD])
			&& cmd.reverse_jog_request == $past(ser_r[B_SER_RVS]);
	endproperty
	a_jog_ser: assert property (p_jog_ser) else $error("jog not from serial");

	property p_data_io;
		src_r[B_DATA_SRC] |=> cmd.op_sel == $past(din.operation_select_bits);
	endproperty
	a_data_io: assert property (p_data_io) else $error("data select wrong");

	property p_release_nc;
		pol_r[B_REL_NC] |=> cmd.release_act == !$past(din.release_in);
	endproperty
	a_release_nc: assert property (p_release_nc) else $error("release polarity wrong");

	property p_sensor_a_nc;
		pol_r[B_SENSOR_A_NC] |=> cmd.sensor_a_hit == !$past(din.sensor_a);
	endproperty
	a_sensor_a_nc: assert property (p_sensor_a_nc) else $error("sensor_a polarity wrong");

	property p_ot_action;
		cmd_nxt.ot_pos || cmd_nxt.ot_neg |=> cmd.ot_decel == $past(src_r[B_OT_DECEL]);
	endproperty
	a_ot_action: assert property (p_ot_action) else $error("overtravel action wrong");

	property p_no_encoder;
		!enc_present && osel_r[OSEL_W-1:0] == OS_MISS |=> !general_output_1;
	endproperty
	a_no_encoder: assert property (p_no_encoder) else $error("misstep without encoder");

endmodule
